// *** core/dcs_device.sv ***
// Clock generator digital core: dividers, serial output stop and coincidence pulse
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module dcs_device (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    dcs_link_if.dev LINK,
    input wire logic I_POST_DIV_SEL,
    input wire logic [dcs_pkg::FB_SEL_W-1:0] I_FEEDBACK_DIV_SEL,
    input wire logic [dcs_pkg::BANK_SEL_W-1:0] I_BANK_A_DIV_SEL,
    input wire logic [dcs_pkg::BANK_SEL_W-1:0] I_BANK_B_DIV_SEL,
    input wire logic [dcs_pkg::BANK_SEL_W-1:0] I_BANK_C_DIV_SEL,
    output logic [3:0] O_BANK_A_OUT,
    output logic [3:0] O_BANK_B_OUT,
    output logic [3:0] O_BANK_C_OUT,
    output logic O_FEEDBACK_OUT,
    output logic O_COINCIDENCE_PULSE_N
);
    import dcs_pkg::*;

    // ---------------- Link domain ----------------
    logic data_s1_r;            // Data synchroniser, first stage
    logic data_s2_r;            // Data synchroniser, second stage
    logic rx_busy_r;            // Frame in progress
    logic [3:0] rx_cnt_r;       // Enable bits received so far
    logic [11:0] rx_shift_r;    // Bits being collected
    logic [11:0] rx_word_r;     // Last complete word, stable between frames
    logic rx_tog_r;             // Toggles once per complete word

    // Data pin synchroniser on the serial clock
    always_ff @(posedge LINK.stop_clk or negedge I_RESETN) begin
        if (!I_RESETN) begin
            data_s1_r <= 1'b1;
            data_s2_r <= 1'b1;
        end else begin
            data_s1_r <= LINK.stop_data;
            data_s2_r <= data_s1_r;
        end
    end

    // Frame receiver, one bit per rising serial edge
    always_ff @(posedge LINK.stop_clk or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= 4'h0;
            rx_shift_r <= 12'h000;
        end else if (!rx_busy_r) begin
            // Idle line is high, a low level opens a frame
            if (data_s2_r == START_BIT) begin
                rx_busy_r <= 1'b1;
                rx_cnt_r <= 4'h0;
            end
        end else begin
            // First bit lands in position 0, fixed order
            rx_shift_r[rx_cnt_r] <= data_s2_r;
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == 4'(EN_BITS - 1)) begin
                rx_busy_r <= 1'b0;
            end
        end
    end

    // Word hand-off: publish only once the twelfth bit is in
    always_ff @(posedge LINK.stop_clk or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rx_word_r <= EN_RESET;
            rx_tog_r <= 1'b0;
        end else if (rx_busy_r && rx_cnt_r == 4'(EN_BITS - 1)) begin
            rx_word_r <= {data_s2_r, rx_shift_r[10:0]};
            rx_tog_r <= ~rx_tog_r;
        end
    end

    // ---------------- Reference (VCO) domain ----------------
    logic tog_s1_r;             // Toggle synchroniser, first stage
    logic tog_s2_r;             // Toggle synchroniser, second stage
    logic tog_s3_r;             // Edge detect of the toggle
    logic [11:0] en_pend_r;     // Newest enables, not yet applied
    logic [11:0] en_eff_r;      // Enables in force per output
    logic [9:0] cfg_s1_r;       // Select pin synchroniser, first stage
    logic [9:0] cfg_s2_r;       // Select pin synchroniser, second stage
    logic [9:0] cfg_r;          // Settings in force
    logic restart;              // Settings changed, realign all dividers
    logic [5:0] per [4];        // Period per divider: A, B, C, feedback
    logic [5:0] half [4];       // High time per divider
    logic [5:0] ph_r [4];       // Phase per divider, rising edge at zero
    logic [3:0] lvl;            // Divided clock levels
    logic [6:0] hyp;            // Coincidence repeat period
    logic [6:0] hyp_r;          // Position within it, coincidence at zero
    logic [5:0] fast;           // Faster of banks A and C
    logic [6:0] fast2;          // Twice that
    logic sync_low;             // Pulse asserted
    logic [11:0] src;           // Ungated stoppable levels

    // Toggle crossing; the word itself is stable for a whole frame after it
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
        end else begin
            tog_s1_r <= rx_tog_r;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
        end
    end

    // Pending enables follow each complete word
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            en_pend_r <= EN_RESET;
        end else if (tog_s2_r != tog_s3_r) begin
            en_pend_r <= rx_word_r;
        end
    end

    // Static pins, synchronised; a change restarts the dividers
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cfg_s1_r <= 10'h000;
            cfg_s2_r <= 10'h000;
            cfg_r <= 10'h000;
        end else begin
            cfg_s1_r <= {I_POST_DIV_SEL, I_FEEDBACK_DIV_SEL, I_BANK_A_DIV_SEL,
                         I_BANK_B_DIV_SEL, I_BANK_C_DIV_SEL};
            cfg_s2_r <= cfg_s1_r;
            cfg_r <= cfg_s2_r;
        end
    end

    assign restart = (cfg_s2_r != cfg_r);

    // Ratio lookup; post-two doubles every bank ratio
    always_comb begin
        half[0] = HALF_A[cfg_r[5:4]] << cfg_r[9];
        half[1] = HALF_B[cfg_r[3:2]] << cfg_r[9];
        half[2] = HALF_C[cfg_r[1:0]] << cfg_r[9];
        // Feedback list already carries the post-divide, keeps output to reference ratio for codes 0 to 5
        half[3] = (cfg_r[9] ? FB_DIV2[cfg_r[8:6]] : FB_DIV1[cfg_r[8:6]]) >> 1;
        for (int k = 0; k < 4; k++) begin
            per[k] = half[k] << 1;
        end
    end

    // One phase counter per divider, all aligned by reset or restart
    for (genvar g = 0; g < 4; g++) begin : g_div
        always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
            if (!I_RESETN) begin
                ph_r[g] <= 6'h00;
            end else if (restart || ph_r[g] == per[g] - 6'h01) begin
                ph_r[g] <= 6'h00;
            end else begin
                ph_r[g] <= ph_r[g] + 6'h01;
            end
        end
        assign lvl[g] = (ph_r[g] < half[g]);
    end

    // Coincidence timing of banks A and C
    assign hyp = lcm(per[0], per[2]);
    assign fast = (per[0] < per[2]) ? per[0] : per[2];
    assign fast2 = {fast, 1'b0};

    // Position within the repeat period; zero is a shared rising edge
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            hyp_r <= 7'h00;
        end else if (restart || hyp_r == hyp - 7'h01) begin
            hyp_r <= 7'h00;
        end else begin
            hyp_r <= hyp_r + 7'h01;
        end
    end

    // Low from two fast periods before to one before each coincidence;
    // equal periods leave no gap, so the pulse then stays asserted
    always_comb begin
        if (hyp < fast2) begin
            sync_low = 1'b1;
        end else begin
            sync_low = (hyp_r >= hyp - fast2) && (hyp_r < hyp - {1'b0, fast});
        end
    end

    // Stoppable sources in enable-bit order
    always_comb begin
        src[EN_POS_A +: 4] = {4{lvl[0]}};
        src[EN_POS_B +: 4] = {4{lvl[1]}};
        src[EN_POS_C +: 3] = {3{lvl[2]}};
        src[EN_POS_SYNC] = ~sync_low;
    end

    // Enables change only while the source is low, so no runt pulse
    for (genvar e = 0; e < EN_BITS; e++) begin : g_en
        always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
            if (!I_RESETN) begin
                en_eff_r[e] <= EN_RESET[e];
            end else if (!src[e]) begin
                en_eff_r[e] <= en_pend_r[e];
            end
        end
    end

    // Registered outputs; a stopped output sits low
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_BANK_A_OUT <= 4'h0;
            O_BANK_B_OUT <= 4'h0;
            O_BANK_C_OUT <= 4'h0;
            O_FEEDBACK_OUT <= 1'b0;
            O_COINCIDENCE_PULSE_N <= 1'b1;
        end else begin
            O_BANK_A_OUT <= src[EN_POS_A +: 4] & en_eff_r[EN_POS_A +: 4];
            O_BANK_B_OUT <= src[EN_POS_B +: 4] & en_eff_r[EN_POS_B +: 4];
            // Output zero of bank C is never gated
            O_BANK_C_OUT <= {src[EN_POS_C +: 3] & en_eff_r[EN_POS_C +: 3], lvl[2]};
            O_FEEDBACK_OUT <= lvl[3];
            O_COINCIDENCE_PULSE_N <= src[EN_POS_SYNC] & en_eff_r[EN_POS_SYNC];
        end
    end

endmodule // dcs_device

`default_nettype wire

// *** core/dcs_pkg.sv ***
// Package of constants and lookups shared by both ends of the clock-stop link
package dcs_pkg;

    // Serial enable word
    localparam int EN_BITS = 12;                  // Stoppable outputs
    localparam logic [11:0] EN_RESET = 12'hFFF;   // All outputs run after reset
    // Enable bit positions in the received word, first bit received is bit 0
    localparam int EN_POS_A = 0;                  // Bank A outputs 0..3
    localparam int EN_POS_B = 4;                  // Bank B outputs 0..3
    localparam int EN_POS_C = 8;                  // Bank C outputs 1..3
    localparam int EN_POS_SYNC = 11;              // Coincidence pulse output
    localparam logic START_BIT = 1'b0;            // Frame start level
    localparam logic IDLE_BIT = 1'b1;             // Line level between frames

    // Select pin widths
    localparam int FB_SEL_W = 3;
    localparam int BANK_SEL_W = 2;

    // Divider ratio half-values, post-divide by one, index is the select code
    localparam logic [5:0] HALF_A [4] = '{6'h02, 6'h03, 6'h04, 6'h06};  // 4/6/8/12
    localparam logic [5:0] HALF_B [4] = '{6'h02, 6'h03, 6'h04, 6'h05};  // 4/6/8/10
    localparam logic [5:0] HALF_C [4] = '{6'h01, 6'h02, 6'h03, 6'h04};  // 2/4/6/8
    // Feedback full ratios, codes past the list repeat the last ratio
    localparam logic [5:0] FB_DIV1 [8] = '{6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h10, 6'h10, 6'h10};
    localparam logic [5:0] FB_DIV2 [8] = '{6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h20, 6'h28, 6'h28};

    // Host register map, byte addresses on the Avalon-MM port
    localparam logic [3:0] REG_ENABLE = 4'h0;     // Enable word, write sends a frame
    localparam logic [3:0] REG_STATUS = 4'h4;     // Bit 0 busy
    localparam int STATUS_BUSY = 0;

    // Link clock divider in the host, half period in reference clocks
    localparam int LINK_HALF = 2;

    // Least common multiple of two small periods, the hyperperiod of two banks
    function automatic logic [6:0] lcm(input logic [5:0] x, input logic [5:0] y);
        int res;
        int m;
        res = 0;
        for (int i = 16; i >= 1; i--) begin
            m = int'(x) * i;
            if ((m % int'(y)) == 0) begin
                res = m;
            end
        end
        return res[6:0];
    endfunction

endpackage

// *** core/dcs_link_if.sv ***
// Interface joining the serial clock-stop controller and the clock generator
`timescale 1ns/1ps
`default_nettype none

interface dcs_link_if;
    logic stop_clk;     // Free-running serial clock, made by the controller
    logic stop_data;    // Serial enable data, NRZ, idle high

    // Controller end drives both wires
    modport host (output stop_clk, output stop_data);
    // Generator end only listens
    modport dev (input stop_clk, input stop_data);
endinterface

`default_nettype wire

// *** core/dcs_host.sv ***
// Serial clock-stop controller with an Avalon-MM register port
`timescale 1ns/1ps
`default_nettype none

module dcs_host #(
    parameter int HALF = dcs_pkg::LINK_HALF  // Link clock half period in reference clocks
) (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    dcs_link_if.host LINK,
    input wire logic [3:0] I_ADDRESS,
    input wire logic I_READ,
    input wire logic I_WRITE,
    input wire logic [31:0] I_WRITEDATA,
    output logic [31:0] O_READDATA,
    output logic O_WAITREQUEST
);
    import dcs_pkg::*;

    logic [7:0] div_r;          // Link clock divider count
    logic clk_r;                // Link clock level
    logic fall;                 // Link clock about to fall
    logic [11:0] word_r;        // Enable word last written
    logic go_r;                 // Frame requested, not yet started
    logic busy_r;               // Frame on the wire
    logic [3:0] bit_r;          // Bits still to send after the current one
    logic [12:0] sh_r;          // Enable bits with an idle bit on top, LSB out first
    logic data_r;               // Data line level
    logic acc;                  // Bus transfer completes this edge

    assign fall = clk_r && (div_r == 8'(HALF - 1));
    assign acc = (I_READ || I_WRITE) && !O_WAITREQUEST;

    // Free-running link clock from the reference clock
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            div_r <= 8'h00;
            clk_r <= 1'b0;
        end else if (div_r == 8'(HALF - 1)) begin
            div_r <= 8'h00;
            clk_r <= ~clk_r;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // One wait cycle per request, answer on the following edge
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_WAITREQUEST <= 1'b1;
        end else begin
            O_WAITREQUEST <= !((I_READ || I_WRITE) && O_WAITREQUEST);
        end
    end

    // Read data, unmapped reads return zero
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_READDATA <= 32'h00000000;
        end else if (I_READ && O_WAITREQUEST) begin
            if (I_ADDRESS == REG_ENABLE) begin
                O_READDATA <= {20'h00000, word_r};
            end else if (I_ADDRESS == REG_STATUS) begin
                O_READDATA <= {31'h00000000, busy_r || go_r};
            end else begin
                O_READDATA <= 32'h00000000;
            end
        end
    end

    // Enable word; writes during a frame are ignored
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            word_r <= EN_RESET;
        end else if (acc && I_WRITE && I_ADDRESS == REG_ENABLE && !busy_r && !go_r) begin
            word_r <= I_WRITEDATA[11:0];
        end
    end

    // Frame request, cleared once the start bit goes out
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            go_r <= 1'b0;
        end else if (acc && I_WRITE && I_ADDRESS == REG_ENABLE && !busy_r && !go_r) begin
            go_r <= 1'b1;
        end else if (fall && !busy_r) begin
            go_r <= 1'b0;
        end
    end

    // Shifter; data changes on the falling link edge, away from sampling
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            busy_r <= 1'b0;
            bit_r <= 4'h0;
            sh_r <= 13'h1FFF;
            data_r <= IDLE_BIT;
        end else if (fall) begin
            if (busy_r) begin
                data_r <= sh_r[0];
                sh_r <= {1'b1, sh_r[12:1]};
                bit_r <= bit_r - 4'h1;
                if (bit_r == 4'h0) begin
                    busy_r <= 1'b0;
                    data_r <= IDLE_BIT;
                end
            end else if (go_r) begin
                data_r <= START_BIT;
                sh_r <= {1'b1, word_r};
                bit_r <= 4'(EN_BITS);
                busy_r <= 1'b1;
            end
        end
    end

    // Bus of the link driven by flip-flops
    assign LINK.stop_clk = clk_r;
    assign LINK.stop_data = data_r;

endmodule // dcs_host

`default_nettype wire

// *** tb/dcs_link_sva.sv ***
// Concurrent checks on the clock-stop link and the generator outputs
`timescale 1ns/1ps
`default_nettype none

module dcs_link_sva #(
    parameter int HALF = dcs_pkg::LINK_HALF  // Link clock half period in reference clocks
) (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic stop_clk,
    input wire logic stop_data,
    input wire logic I_POST_DIV_SEL,
    input wire logic [dcs_pkg::FB_SEL_W-1:0] I_FEEDBACK_DIV_SEL,
    input wire logic [dcs_pkg::BANK_SEL_W-1:0] I_BANK_A_DIV_SEL,
    input wire logic [dcs_pkg::BANK_SEL_W-1:0] I_BANK_B_DIV_SEL,
    input wire logic [dcs_pkg::BANK_SEL_W-1:0] I_BANK_C_DIV_SEL,
    input wire logic [3:0] O_BANK_A_OUT,
    input wire logic [3:0] O_BANK_B_OUT,
    input wire logic [3:0] O_BANK_C_OUT,
    input wire logic O_FEEDBACK_OUT,
    input wire logic O_COINCIDENCE_PULSE_N
);
    import dcs_pkg::*;

    logic [5:0] settle_r;  // Cycles since reset, saturating
    logic [7:0] hi_a_r, hi_b_r, hi_c_r, hi_f_r;  // Current high run of each watched clock
    logic [7:0] lo_s_r;  // Current low run of the coincidence pulse
    logic [7:0] since_r;  // Cycles since the pulse ended
    logic [3:0] clk_run_r;  // Cycles since the link clock last moved
    logic ok;  // Pin restart after reset is over
    logic [7:0] post, ha, hb, hc, hf, tmin;  // Expected half periods and fast period

    // Runs judged only after pin restart settles
    assign ok = (settle_r == 6'h3F);
    assign post = I_POST_DIV_SEL ? 8'h02 : 8'h01;
    assign ha = 8'(HALF_A[I_BANK_A_DIV_SEL]) * post;
    assign hb = 8'(HALF_B[I_BANK_B_DIV_SEL]) * post;
    assign hc = 8'(HALF_C[I_BANK_C_DIV_SEL]) * post;
    assign hf = I_POST_DIV_SEL ? 8'(FB_DIV2[I_FEEDBACK_DIV_SEL] >> 1) : 8'(FB_DIV1[I_FEEDBACK_DIV_SEL] >> 1);
    assign tmin = (ha < hc) ? ha * 8'h02 : hc * 8'h02;

    // Settling counter
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            settle_r <= 6'h00;
        end else if (!ok) begin
            settle_r <= settle_r + 6'h01;
        end
    end

    // Run lengths of the watched outputs and the link clock
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            hi_a_r <= 8'h00;
            hi_b_r <= 8'h00;
            hi_c_r <= 8'h00;
            hi_f_r <= 8'h00;
            lo_s_r <= 8'h00;
            since_r <= 8'h00;
            clk_run_r <= 4'h0;
        end else begin
            hi_a_r <= O_BANK_A_OUT[0] ? hi_a_r + 8'h01 : 8'h00;
            hi_b_r <= O_BANK_B_OUT[0] ? hi_b_r + 8'h01 : 8'h00;
            hi_c_r <= O_BANK_C_OUT[0] ? hi_c_r + 8'h01 : 8'h00;
            hi_f_r <= O_FEEDBACK_OUT ? hi_f_r + 8'h01 : 8'h00;
            lo_s_r <= O_COINCIDENCE_PULSE_N ? 8'h00 : lo_s_r + 8'h01;
            since_r <= $rose(O_COINCIDENCE_PULSE_N) ? 8'h00 : since_r + 8'h01;
            clk_run_r <= $changed(stop_clk) ? 4'h0 : clk_run_r + 4'h1;
        end
    end

    default clocking dcs_cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RESETN);

    // A shortened high phase shows as a wrong run length
    bank_a_high_a: assert property (ok && $fell(O_BANK_A_OUT[0]) |-> hi_a_r == ha)
        else $error("bank A high time wrong");
    bank_b_high_a: assert property (ok && $fell(O_BANK_B_OUT[0]) |-> hi_b_r == hb)
        else $error("bank B high time wrong");
    bank_c_high_a: assert property (ok && $fell(O_BANK_C_OUT[0]) |-> hi_c_r == hc)
        else $error("bank C high time wrong");
    feedback_high_a: assert property (ok && $fell(O_FEEDBACK_OUT) |-> hi_f_r == hf)
        else $error("feedback high time wrong");
    // Equal bank periods leave no gap, so pulse checks skip them
    sync_width_a: assert property (ok && ha != hc && $rose(O_COINCIDENCE_PULSE_N) |-> lo_s_r == tmin)
        else $error("coincidence pulse width wrong");
    sync_lead_a: assert property (ok && ha != hc && $rose(O_BANK_A_OUT[0]) && $rose(O_BANK_C_OUT[0]) |-> since_r == tmin - 8'h01)
        else $error("coincidence pulse lead wrong");
    link_clk_free_a: assert property (ok && $changed(stop_clk) |-> clk_run_r == 4'(HALF - 1))
        else $error("link clock half period wrong");
    // Hold of three assumes the default half period of two
    link_bit_hold_a: assert property (ok && $changed(stop_data) |=> $stable(stop_data) [*3])
        else $error("link bit shorter than one period");
    link_setup_a: assert property ($rose(stop_clk) |-> $stable(stop_data) ##1 $stable(stop_data))
        else $error("link data moves at sampling edge");

    sync_seen_c: cover property (ok && $rose(O_COINCIDENCE_PULSE_N));
    frame_seen_c: cover property (ok && $fell(stop_data));
    bank_stopped_c: cover property (ok && O_BANK_A_OUT == 4'h0 && O_BANK_C_OUT[0]);

endmodule // dcs_link_sva

`default_nettype wire

// *** tb/dcs_tb.sv ***
// Self-checking bench: host and generator joined over the clock-stop link
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module dcs_tb;
    import dcs_pkg::*;

    logic clk = 1'h0;  // Reference clock
    logic rst_n = 1'h0;  // Async reset, active low
    logic post_sel = 1'h0;  // Post-divide select
    logic [2:0] fb_sel = 3'h0;  // Feedback select
    logic [1:0] a_sel = 2'h0, b_sel = 2'h0, c_sel = 2'h0;  // Bank selects
    logic [3:0] address = 4'h0;  // Bus address
    logic rd = 1'h0, wr = 1'h0;  // Bus strobes
    logic [31:0] wdata = 32'h0;  // Bus write data
    logic [31:0] rdata;  // Bus read data
    logic wait_req;  // Bus wait
    logic [3:0] qa, qb, qc;  // Bank outputs
    logic feedback_out, sync_n;  // Feedback and coincidence outputs
    int error_cnt = 0;  // Mismatches
    int n_tests = 0;  // Comparisons
    int ra[4] = '{4, 6, 8, 12};  // Bank A ratios
    int rb[4] = '{4, 6, 8, 10};  // Bank B ratios
    int rc[4] = '{2, 4, 6, 8};  // Bank C ratios
    int rf[16] = '{4, 6, 8, 10, 12, 16, 16, 16, 8, 12, 16, 20, 24, 32, 40, 40};  // Feedback totals

    // 20 MHz reference
    always #25 clk = ~clk;

    dcs_link_if dcs_link_if_i ();

    dcs_host dcs_host_i (.I_REF_CLK(clk), .I_RESETN(rst_n), .LINK(dcs_link_if_i), .I_ADDRESS(address),
        .I_READ(rd), .I_WRITE(wr), .I_WRITEDATA(wdata), .O_READDATA(rdata), .O_WAITREQUEST(wait_req));

    dcs_device dcs_device_i (.I_REF_CLK(clk), .I_RESETN(rst_n), .LINK(dcs_link_if_i), .I_POST_DIV_SEL(post_sel),
        .I_FEEDBACK_DIV_SEL(fb_sel), .I_BANK_A_DIV_SEL(a_sel), .I_BANK_B_DIV_SEL(b_sel),
        .I_BANK_C_DIV_SEL(c_sel), .O_BANK_A_OUT(qa), .O_BANK_B_OUT(qb), .O_BANK_C_OUT(qc),
        .O_FEEDBACK_OUT(feedback_out), .O_COINCIDENCE_PULSE_N(sync_n));

    dcs_link_sva #(.HALF(LINK_HALF)) dcs_link_sva_i (.I_REF_CLK(clk), .I_RESETN(rst_n),
        .stop_clk(dcs_link_if_i.stop_clk), .stop_data(dcs_link_if_i.stop_data), .I_POST_DIV_SEL(post_sel),
        .I_FEEDBACK_DIV_SEL(fb_sel), .I_BANK_A_DIV_SEL(a_sel), .I_BANK_B_DIV_SEL(b_sel),
        .I_BANK_C_DIV_SEL(c_sel), .O_BANK_A_OUT(qa), .O_BANK_B_OUT(qb), .O_BANK_C_OUT(qc),
        .O_FEEDBACK_OUT(feedback_out), .O_COINCIDENCE_PULSE_N(sync_n));

    // Counts, verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Selects change only under reset, since a live change is not glitch-free
    task automatic restart(input logic [3:0] k);
        rst_n <= 1'h0;
        post_sel <= k[3];
        fb_sel <= k[2:0];
        a_sel <= k[1:0];
        b_sel <= k[1:0];
        c_sel <= k[1:0];
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        repeat (64) @(posedge clk);
    endtask

    // One Avalon transfer, held until wait is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        address <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (wait_req === 1'h0) break;
        end
        q = rdata;
        wr <= 1'h0;
        rd <= 1'h0;
        @(posedge clk);
        if (n == 16) begin
            error_cnt++;
            stop_test();
        end
    endtask

    // Captures start, twelve bits and idle level at rising link clock
    task automatic watch(output logic [13:0] seen, output int span);
        logic prev;
        int k, t;
        prev = 1'h1;
        k = 0;
        t = 0;
        span = 0;
        seen = '1;
        for (int n = 0; n < 400 && k < 14; n++) begin
            @(negedge clk);
            t++;
            if (dcs_link_if_i.stop_clk && !prev && (k > 0 || !dcs_link_if_i.stop_data)) begin
                seen[k] = dcs_link_if_i.stop_data;
                if (k == 1) span = t;
                k++;
                t = 0;
            end
            prev = dcs_link_if_i.stop_clk;
        end
    endtask

    // Sends an enable word; a spoiled send writes again while busy
    task automatic send(input logic [11:0] en, input logic spoil);
        logic [13:0] seen;
        logic [31:0] q;
        int span;
        fork
            begin
                bus(1'h1, REG_ENABLE, {20'h00000, en}, q);
                if (spoil) begin
                    bus(1'h1, REG_ENABLE, {20'h00000, ~en | 12'h800}, q);
                    bus(1'h0, REG_STATUS, 32'h0, q);
                    `CHK("busy in frame", 1'h1, q[STATUS_BUSY])
                end
            end
            watch(seen, span);
        join
        @(posedge clk);
        `CHK("frame on wire", {1'h1, en, 1'h0}, seen)
        `CHK("bit period", 2 * LINK_HALF, span)
        for (int n = 0; n < 20; n++) begin
            bus(1'h0, REG_STATUS, 32'h0, q);
            if (q[STATUS_BUSY] === 1'h0) break;
        end
        `CHK("busy cleared", 1'h0, q[STATUS_BUSY])
        bus(1'h0, REG_ENABLE, 32'h0, q);
        `CHK("enable word", {20'h00000, en}, q)
    endtask

    // Which outputs were seen high during a short window
    task automatic observe(output logic [12:0] ran);
        ran = '0;
        repeat (24) begin
            @(negedge clk);
            ran = ran | {feedback_out, qc, qb, qa};
        end
        @(posedge clk);
    endtask

    task automatic test_regs();
        logic [31:0] q;
        logic prev;
        int rises;
        bus(1'h1, 4'h8, 32'hFFFFFFFF, q);
        bus(1'h0, 4'h8, 32'h0, q);
        `CHK("unmapped read", 32'h0, q)
        bus(1'h0, REG_STATUS, 32'h0, q);
        `CHK("idle status", 32'h0, q)
        rises = 0;
        @(negedge clk);
        prev = dcs_link_if_i.stop_clk;
        repeat (40) begin
            @(negedge clk);
            if (dcs_link_if_i.stop_clk && !prev) rises++;
            prev = dcs_link_if_i.stop_clk;
        end
        `CHK("idle link clock", 40 / (2 * LINK_HALF), rises)
        `CHK("idle link data", 1'h1, dcs_link_if_i.stop_data)
        @(posedge clk);
        $display("test regs done");
    endtask

    // Every select code under both post settings; window fits all periods
    task automatic test_ratios();
        int cnt[4];
        int m;
        logic [3:0] prev, cur;
        for (int k = 0; k < 16; k++) begin
            restart(4'(k));
            m = (k > 7) ? 2 : 1;
            cnt = '{0, 0, 0, 0};
            @(negedge clk);
            prev = {feedback_out, qc[0], qb[0], qa[0]};
            repeat (960) begin
                @(negedge clk);
                cur = {feedback_out, qc[0], qb[0], qa[0]};
                for (int j = 0; j < 4; j++) cnt[j] += (cur[j] && !prev[j]) ? 1 : 0;
                prev = cur;
            end
            @(posedge clk);
            `CHK("bank A edges", 960 / (ra[k % 4] * m), cnt[0])
            `CHK("bank B edges", 960 / (rb[k % 4] * m), cnt[1])
            `CHK("bank C edges", 960 / (rc[k % 4] * m), cnt[2])
            `CHK("feedback edges", 960 / rf[k], cnt[3])
        end
        $display("test ratios done");
    endtask

    // Walks one running bit across the word; coincidence bit stays set
    task automatic test_enables();
        logic [11:0] en;
        logic [12:0] ran;
        restart(4'h0);
        observe(ran);
        `CHK("runs after reset", 13'h1FFF, ran)
        for (int i = 0; i < 13; i++) begin
            en = (i < 11) ? (12'h800 | (12'h001 << i)) : ((i == 11) ? 12'h800 : 12'hFFF);
            send(en, i == 5);
            repeat (40) @(posedge clk);
            observe(ran);
            `CHK("running outputs", {1'h1, en[10:8], 1'h1, en[7:4], en[3:0]}, ran)
        end
        $display("test enables done");
    endtask

    initial begin
        restart(4'h0);
        test_regs();
        test_ratios();
        test_enables();
        stop_test();
    end

endmodule // dcs_tb

`default_nettype wire
